// ### core/sfe_pkg.sv
package sfe_pkg;

  // --------------------------------------------------------------
  // opcodes
  // --------------------------------------------------------------
  localparam logic [7:0] OP_BLOCK32_ERASE = 8'h52;
  localparam logic [7:0] OP_BLOCK64_ERASE = 8'hD8;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'hC7;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_WRITE_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_WRITE_LATCH_CLEAR = 8'h04;
  localparam logic [7:0] OP_STATUS_WRITE_ARM = 8'h50;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_ID_READ_A = 8'h90;
  localparam logic [7:0] OP_ID_READ_B = 8'hAB;
  localparam logic [7:0] OP_ID_READ_LONG = 8'h9F;

  // --------------------------------------------------------------
  // frame lengths in bits
  // --------------------------------------------------------------
  localparam logic [11:0] BITS_OPCODE = 12'h008;
  localparam logic [11:0] BITS_WITH_DATA = 12'h010;
  localparam logic [11:0] BITS_WITH_ADDR = 12'h020;

  // --------------------------------------------------------------
  // status byte layout
  // --------------------------------------------------------------
  localparam int ST_BUSY = 0;
  localparam int ST_LATCH = 1;
  localparam int ST_BP_LO = 2;
  localparam int ST_INC = 6;
  localparam int ST_LOCK = 7;
  localparam logic [3:0] BP_RESET = 4'hF;
  localparam logic LOCK_RESET = 1'b0;

  // --------------------------------------------------------------
  // identity bytes (values arbitrary)
  // --------------------------------------------------------------
  localparam logic [7:0] MAKER_CODE = 8'h5A;
  localparam logic [7:0] PART_CODE = 8'h3C;
  localparam logic [7:0] MEM_TYPE_CODE = 8'h21;
  localparam logic [7:0] CAPACITY_CODE = 8'h16;

  // --------------------------------------------------------------
  // erase kinds and timing
  // --------------------------------------------------------------
  localparam logic [1:0] ERASE_BLOCK32 = 2'h1;
  localparam logic [1:0] ERASE_BLOCK64 = 2'h2;
  localparam logic [1:0] ERASE_CHIP = 2'h3;
  localparam int CLK_PERIOD_NS = 40;
  localparam int BLOCK_ERASE_TIME_US = 1000;
  localparam int CHIP_ERASE_TIME_US = 2000;
  localparam int BLOCK_ERASE_CYCLES =
    (BLOCK_ERASE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CHIP_ERASE_CYCLES =
    (CHIP_ERASE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // --------------------------------------------------------------
  // carriers
  // --------------------------------------------------------------
  typedef struct packed {
    logic sck;
    logic cs_n;
    logic si;
    logic wp_n;
  } sfe_pins_t;

  localparam sfe_pins_t PINS_IDLE = '{sck: 1'b0, cs_n: 1'b1, si: 1'b0,
                                      wp_n: 1'b1};

  typedef struct packed {
    logic sck_q;
    logic cs_q;
    logic [11:0] cnt;
    logic [7:0] shift;
    logic [7:0] opcode;
    logic [23:0] addr;
    logic [7:0] data;
    logic latch;
    logic inc;
    logic [3:0] bp;
    logic lock;
    logic busy;
    logic armed;
    logic [31:0] timer;
    logic erase_req;
    logic [1:0] erase_kind;
    logic [23:0] erase_addr;
    logic so;
    logic so_oe;
  } sfe_state_t;

endpackage : sfe_pkg

// ### core/sfe_sync.sv
`timescale 1ns/1ps
module sfe_sync (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire sfe_pkg::sfe_pins_t pins_in,
  output sfe_pkg::sfe_pins_t pins_out
);

  // --------------------------------------------------------------
  // two-stage synchroniser; only the second stage is visible
  // --------------------------------------------------------------
  sfe_pkg::sfe_pins_t meta_reg;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_reg <= sfe_pkg::PINS_IDLE;
      pins_out <= sfe_pkg::PINS_IDLE;
    end else begin
      meta_reg <= pins_in;
      pins_out <= meta_reg;
    end
  end

endmodule : sfe_sync

// ### core/sfe_core.sv
`timescale 1ns/1ps
// Notes on behaviour
// - 52H erases 32K block by A23..A15
// - D8H erases 64K block by A23..A16
// - block erase into protected region ignored
// - 60H or C7H erases whole array
// - chip erase refused if anything protected
// - writes execute on closing select rise
// - erase self-timed, busy flag set meanwhile
// - status read answered even while busy
// - status byte repeats until select rises
// - latch set command sets write latch
// - status write clears write latch
// - latch clear resets latch and increment flag
// - latch clear never aborts running operation
// - status write must follow arm immediately unless latch is set
// - status write changes protect and lock
// - locked and pin low ignores status write
// - pin low lets lock only rise
// - unlocked status write changes bits together
// - 90H/ABH alternate maker and part codes
// - 9FH gives maker, type, capacity bytes
// - 04H latch clear, 05H status read
module sfe_core #(
  parameter int BLOCK_ERASE_CYCLES = sfe_pkg::BLOCK_ERASE_CYCLES,
  parameter int CHIP_ERASE_CYCLES = sfe_pkg::CHIP_ERASE_CYCLES
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic si_in,
  input wire logic wp_n_in,
  input wire logic inc_set_in,
  output logic so_out,
  output logic so_oe_out,
  output logic busy_out,
  output logic [7:0] status_out,
  output logic erase_req_out,
  output logic [1:0] erase_kind_out,
  output logic [23:0] erase_addr_out
);

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  // protection grows downward from the top 64K block of a 4 MByte array
  function automatic logic is_protected(input logic [5:0] blk,
                                        input logic [3:0] bp);
    int lim;
    lim = 0;
    if (bp == 4'h0) begin
      return 1'b0;
    end
    if (bp >= 4'h7) begin
      return 1'b1;
    end
    lim = 64 - (1 << (int'(bp) - 1));
    return int'(blk) >= lim;
  endfunction : is_protected

  function automatic logic [7:0] status_byte(input sfe_pkg::sfe_state_t s);
    logic [7:0] b;
    b = 8'h00;
    b[sfe_pkg::ST_BUSY] = s.busy;
    b[sfe_pkg::ST_LATCH] = s.latch;
    b[sfe_pkg::ST_BP_LO +: 4] = s.bp;
    b[sfe_pkg::ST_INC] = s.inc;
    b[sfe_pkg::ST_LOCK] = s.lock;
    return b;
  endfunction : status_byte

  function automatic logic out_bit(input logic [7:0] op,
                                   input logic [11:0] c,
                                   input logic [7:0] stat,
                                   input logic a0);
    logic [11:0] k;
    logic [7:0] b;
    k = 12'h000;
    b = 8'h00;
    if (op == sfe_pkg::OP_STATUS_READ) begin
      k = c - sfe_pkg::BITS_OPCODE;
      b = stat;
    end else if (op == sfe_pkg::OP_ID_READ_LONG) begin
      k = c - sfe_pkg::BITS_OPCODE;
      unique case (k[4:3])
        2'h0: b = sfe_pkg::MAKER_CODE;
        2'h1: b = sfe_pkg::MEM_TYPE_CODE;
        2'h2: b = sfe_pkg::CAPACITY_CODE;
        2'h3: b = 8'h00;
      endcase
    end else begin
      k = c - sfe_pkg::BITS_WITH_ADDR;
      b = (k[3] ^ a0) ? sfe_pkg::PART_CODE : sfe_pkg::MAKER_CODE;
    end
    return b[3'h7 - k[2:0]];
  endfunction : out_bit

  // --------------------------------------------------------------
  // pin synchronisation and edges
  // --------------------------------------------------------------
  sfe_pkg::sfe_pins_t pins_raw;
  sfe_pkg::sfe_pins_t pins_s;
  sfe_pkg::sfe_state_t st_reg;
  sfe_pkg::sfe_state_t st_next;
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  logic [7:0] shift_new;
  logic out_active;
  logic sw_locked;

  assign pins_raw = '{sck: sck_in, cs_n: cs_n_in, si: si_in,
                      wp_n: wp_n_in};

  sfe_sync u_sync (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .pins_in(pins_raw),
    .pins_out(pins_s)
  );

  assign sck_rise = pins_s.sck & ~st_reg.sck_q;
  assign sck_fall = ~pins_s.sck & st_reg.sck_q;
  assign cs_rise = pins_s.cs_n & ~st_reg.cs_q;
  assign shift_new = {st_reg.shift[6:0], pins_s.si};
  assign sw_locked = ~pins_s.wp_n & st_reg.lock;

  always_comb begin
    out_active = 1'b0;
    if (st_reg.opcode == sfe_pkg::OP_STATUS_READ) begin
      out_active = st_reg.cnt >= sfe_pkg::BITS_OPCODE;
    end else if (st_reg.opcode == sfe_pkg::OP_ID_READ_LONG) begin
      out_active = !st_reg.busy && st_reg.cnt >= sfe_pkg::BITS_OPCODE;
    end else if (st_reg.opcode == sfe_pkg::OP_ID_READ_A ||
                 st_reg.opcode == sfe_pkg::OP_ID_READ_B) begin
      out_active = !st_reg.busy &&
                   st_reg.cnt >= sfe_pkg::BITS_WITH_ADDR;
    end
  end

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.erase_req = 1'b0;
    st_next.sck_q = pins_s.sck;
    st_next.cs_q = pins_s.cs_n;
    // self-timed erase; the array itself is outside this block
    if (st_reg.busy) begin
      if (st_reg.timer <= 32'h0000_0001) begin
        st_next.busy = 1'b0;
        st_next.latch = 1'b0;
        st_next.timer = 32'h0000_0000;
      end else begin
        st_next.timer = st_reg.timer - 32'h0000_0001;
      end
    end
    if (pins_s.cs_n) begin
      st_next.cnt = 12'h000;
      st_next.so_oe = 1'b0;
      if (cs_rise && st_reg.cnt >= sfe_pkg::BITS_OPCODE) begin
        // any finished command disarms; only an 8-bit arm while not busy re-arms
        st_next.armed = 1'b0;
        if (!st_reg.busy) begin
          unique case (st_reg.opcode)
            sfe_pkg::OP_WRITE_LATCH_SET: begin
              if (st_reg.cnt == sfe_pkg::BITS_OPCODE) begin
                st_next.latch = 1'b1;
              end
            end
            sfe_pkg::OP_WRITE_LATCH_CLEAR: begin
              if (st_reg.cnt == sfe_pkg::BITS_OPCODE) begin
                // busy and timer are left running on purpose
                st_next.latch = 1'b0;
                st_next.inc = 1'b0;
              end
            end
            sfe_pkg::OP_STATUS_WRITE_ARM: begin
              st_next.armed = st_reg.cnt == sfe_pkg::BITS_OPCODE;
            end
            sfe_pkg::OP_STATUS_WRITE: begin
              if (st_reg.cnt == sfe_pkg::BITS_WITH_DATA &&
                  (st_reg.armed || st_reg.latch) && !sw_locked) begin
                // with the pin low the lock was 0 here, so it can only rise
                st_next.bp = st_reg.data[sfe_pkg::ST_BP_LO +: 4];
                st_next.lock = st_reg.data[sfe_pkg::ST_LOCK];
                st_next.latch = 1'b0;
              end
            end
            sfe_pkg::OP_BLOCK32_ERASE,
            sfe_pkg::OP_BLOCK64_ERASE: begin
              if (st_reg.cnt == sfe_pkg::BITS_WITH_ADDR && st_reg.latch &&
                  !is_protected(st_reg.addr[21:16], st_reg.bp)) begin
                st_next.busy = 1'b1;
                st_next.timer = 32'(BLOCK_ERASE_CYCLES);
                st_next.erase_req = 1'b1;
                if (st_reg.opcode == sfe_pkg::OP_BLOCK32_ERASE) begin
                  st_next.erase_kind = sfe_pkg::ERASE_BLOCK32;
                  st_next.erase_addr = {st_reg.addr[23:15], 15'h0000};
                end else begin
                  st_next.erase_kind = sfe_pkg::ERASE_BLOCK64;
                  st_next.erase_addr = {st_reg.addr[23:16], 16'h0000};
                end
              end
            end
            sfe_pkg::OP_CHIP_ERASE_A,
            sfe_pkg::OP_CHIP_ERASE_B: begin
              if (st_reg.cnt == sfe_pkg::BITS_OPCODE && st_reg.latch &&
                  st_reg.bp == 4'h0) begin
                st_next.busy = 1'b1;
                st_next.timer = 32'(CHIP_ERASE_CYCLES);
                st_next.erase_req = 1'b1;
                st_next.erase_kind = sfe_pkg::ERASE_CHIP;
                st_next.erase_addr = 24'h000000;
              end
            end
            default: begin
            end
          endcase
        end
      end
    end else if (sck_rise) begin
      // input sampled on the rising clock, msb first
      st_next.shift = shift_new;
      st_next.cnt = st_reg.cnt + 12'h001;
      if (st_reg.cnt == sfe_pkg::BITS_OPCODE - 12'h001) begin
        st_next.opcode = shift_new;
      end
      if (st_reg.cnt >= sfe_pkg::BITS_OPCODE &&
          st_reg.cnt < sfe_pkg::BITS_WITH_ADDR) begin
        st_next.addr = {st_reg.addr[22:0], pins_s.si};
      end
      if (st_reg.cnt >= sfe_pkg::BITS_OPCODE &&
          st_reg.cnt < sfe_pkg::BITS_WITH_DATA) begin
        st_next.data = shift_new;
      end
    end else if (sck_fall) begin
      // output changes after the falling clock
      st_next.so_oe = out_active;
      if (out_active) begin
        st_next.so = out_bit(st_reg.opcode, st_reg.cnt,
                             status_byte(st_reg), st_reg.addr[0]);
      end
    end
    // set wins over a latch clear in the same cycle
    if (inc_set_in) begin
      st_next.inc = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_reg <= '{sck_q: 1'b0, cs_q: 1'b1, cnt: 12'h000, shift: 8'h00,
                  opcode: 8'h00, addr: 24'h000000, data: 8'h00,
                  latch: 1'b0, inc: 1'b0, bp: sfe_pkg::BP_RESET,
                  lock: sfe_pkg::LOCK_RESET, busy: 1'b0, armed: 1'b0,
                  timer: 32'h0000_0000, erase_req: 1'b0,
                  erase_kind: 2'h0, erase_addr: 24'h000000,
                  so: 1'b0, so_oe: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign so_out = st_reg.so;
  assign so_oe_out = st_reg.so_oe;
  assign busy_out = st_reg.busy;
  assign status_out = status_byte(st_reg);
  assign erase_req_out = st_reg.erase_req;
  assign erase_kind_out = st_reg.erase_kind;
  assign erase_addr_out = st_reg.erase_addr;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_cmd_end(logic [7:0] op, logic [11:0] bits);
    cs_rise && !st_reg.busy && st_reg.opcode == op && st_reg.cnt == bits;
  endsequence

  sequence s_erase_issue;
    st_reg.erase_req ##0 st_reg.busy;
  endsequence

  a_erase_on_select: assert property (
    st_reg.erase_req |-> $past(cs_rise) && $past(st_reg.latch))
    else $error("erase issued without select rise or latch");
  a_erase_busy_run: assert property (
    st_reg.erase_req |-> s_erase_issue ##1 st_reg.busy[*8])
    else $error("busy did not hold after erase start");
  a_chip_unprot: assert property (
    st_reg.erase_req && st_reg.erase_kind == sfe_pkg::ERASE_CHIP
    |-> st_reg.bp == 4'h0)
    else $error("chip erase while protected");
  a_block_unprot: assert property (
    st_reg.erase_req && st_reg.erase_kind != sfe_pkg::ERASE_CHIP
    |-> !is_protected(st_reg.erase_addr[21:16], st_reg.bp))
    else $error("block erase into protected area");
  a_latch_set: assert property (
    s_cmd_end(sfe_pkg::OP_WRITE_LATCH_SET, sfe_pkg::BITS_OPCODE)
    |=> st_reg.latch)
    else $error("latch set did not set latch");
  a_latch_clear: assert property (
    s_cmd_end(sfe_pkg::OP_WRITE_LATCH_CLEAR, sfe_pkg::BITS_OPCODE)
    ##0 !inc_set_in |=> !st_reg.latch && !st_reg.inc)
    else $error("latch clear left a flag set");
  a_lock_holds: assert property (
    !pins_s.wp_n && st_reg.lock |=> st_reg.lock && $stable(st_reg.bp))
    else $error("locked status register changed");
  a_status_repeat: assert property (
    sck_fall && !pins_s.cs_n && st_reg.cnt >= sfe_pkg::BITS_OPCODE &&
    st_reg.opcode == sfe_pkg::OP_STATUS_READ
    |=> st_reg.so_oe &&
        st_reg.so == $past(status_out[3'h7 - st_reg.cnt[2:0]]))
    else $error("status bit shifted out wrong");
  a_erase_end: assert property (
    st_reg.busy && st_reg.timer == 32'h0000_0001
    |=> !st_reg.busy && !st_reg.latch)
    else $error("erase end left busy or latch");
  a_busy_ignore: assert property (
    st_reg.busy && st_reg.timer > 32'h0000_0001 && cs_rise
    |=> $stable(st_reg.latch) && $stable(st_reg.bp) && !st_reg.erase_req)
    else $error("command acted on while busy");

endmodule : sfe_core

// ### testbench/sfe_host.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// host serial controller, mode 0, 8 clk per sck period
// ------------------------------------------------------------
module sfe_host (
  input wire logic clk_in,
  input wire logic so_in,
  input wire logic so_oe_in,
  output sfe_pkg::sfe_pins_t pins_out,
  output logic rx_done_out,
  output logic [31:0] rx_data_out
);
  sfe_pkg::sfe_pins_t p;

  initial begin
    p = sfe_pkg::PINS_IDLE;
    pins_out = sfe_pkg::PINS_IDLE;
    rx_done_out = 1'b0;
    rx_data_out = 32'h0;
  end

  task set_wp(input logic v);
    @(posedge clk_in);
    p.wp_n = v;
    pins_out <= p;
  endtask : set_wp

  // sck stands still low outside frames; whole struct written once a step
  task frame(input logic [31:0] tx, input int ntx, input int nrx);
    logic [31:0] r;
    r = 32'h0;
    for (int i = 0; i < ntx + nrx; i++) begin
      @(posedge clk_in);
      p.sck = 1'b0;
      p.si = (i < ntx) ? tx[ntx - 1 - i] : ~p.si;
      p.cs_n = 1'b0;
      pins_out <= p;
      repeat (4) @(posedge clk_in);
      p.sck = 1'b1;
      pins_out <= p;
      repeat (3) @(posedge clk_in);
      @(negedge clk_in);
      // a released line reads unknown, never as a stale bit
      if (i >= ntx) r = {r[30:0], so_oe_in ? so_in : 1'bx};
    end
    @(posedge clk_in);
    p.sck = 1'b0;
    pins_out <= p;
    repeat (4) @(posedge clk_in);
    p.cs_n = 1'b1;
    p.si = ~p.si;
    pins_out <= p;
    rx_data_out <= r;
    rx_done_out <= (nrx > 0);
    @(posedge clk_in);
    rx_done_out <= 1'b0;
    repeat (6) @(posedge clk_in);
  endtask : frame
endmodule : sfe_host

// ### testbench/serial_flash_erase_status_id_tb.sv
`timescale 1ns/1ps
module serial_flash_erase_status_id_tb;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic inc_set_in = 1'b0;
  logic so, so_oe, busy, ereq, rx_done;
  logic [7:0] status;
  logic [1:0] ekind;
  logic [23:0] eaddr;
  logic [31:0] rx_data;
  sfe_pkg::sfe_pins_t pins;
  logic [31:0] exp_rx[$];
  logic [31:0] exp_er[$];
  int n_errors = 0;
  int n_checks = 0;
  logic [3:0] bp = 4'hF;
  logic lock = 1'b0;
  logic inc = 1'b0;
  logic latch = 1'b0;
  logic [23:0] a;
  logic [7:0] d;

  always #20 clk_in = ~clk_in;

  // long erase so a status frame fits well inside busy
  sfe_core #(.BLOCK_ERASE_CYCLES(1000), .CHIP_ERASE_CYCLES(1500)) u_dut (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .sck_in(pins.sck),
    .cs_n_in(pins.cs_n), .si_in(pins.si), .wp_n_in(pins.wp_n),
    .inc_set_in(inc_set_in), .so_out(so), .so_oe_out(so_oe),
    .busy_out(busy), .status_out(status), .erase_req_out(ereq),
    .erase_kind_out(ekind), .erase_addr_out(eaddr)
  );

  sfe_host u_host (
    .clk_in(clk_in), .so_in(so), .so_oe_in(so_oe), .pins_out(pins),
    .rx_done_out(rx_done), .rx_data_out(rx_data)
  );

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task complete_run();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  function automatic logic [7:0] st(input logic b);
    return {lock, inc, bp, latch, b};
  endfunction : st

  task cmd(input logic [7:0] op);
    u_host.frame({24'h0, op}, 8, 0);
  endtask : cmd

  task rd(input logic [31:0] tx, input int ntx, input int nrx,
          input logic [31:0] e);
    exp_rx.push_back(e);
    u_host.frame(tx, ntx, nrx);
  endtask : rd

  task chk_st();
    rd({24'h0, sfe_pkg::OP_STATUS_READ}, 8, 8, {24'h0, st(1'b0)});
  endtask : chk_st

  task sw(input logic [7:0] v);
    u_host.frame({16'h0, sfe_pkg::OP_STATUS_WRITE, v}, 16, 0);
  endtask : sw

  task wait_idle();
    for (int k = 0; k < 3000 && busy !== 1'b0; k++) @(posedge clk_in);
    check(busy, 1'b0);
  endtask : wait_idle

  // refused erases are followed by a latch clear to keep state known
  task er(input logic [7:0] op, input logic ok, input logic [1:0] kind,
          input logic [23:0] base);
    cmd(sfe_pkg::OP_WRITE_LATCH_SET);
    latch = 1'b1;
    if (ok) exp_er.push_back({6'h0, kind, base});
    if (kind == sfe_pkg::ERASE_CHIP) cmd(op);
    else u_host.frame({op, a}, 32, 0);
    check(busy, ok);
    if (ok) wait_idle();
    else cmd(sfe_pkg::OP_WRITE_LATCH_CLEAR);
    latch = 1'b0;
  endtask : er

  always @(posedge clk_in) begin
    if (rx_done) check(rx_data, exp_rx.size() ? exp_rx.pop_front() : 'x);
    if (ereq) check({6'h0, ekind, eaddr},
                    exp_er.size() ? exp_er.pop_front() : 'x);
  end

  initial begin
    repeat (60000) @(posedge clk_in);
    n_errors++;
    complete_run();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'h26C4E942));
    repeat (16) @(posedge clk_in);
    reset_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    check({status, so_oe, busy}, {8'h3C, 2'b00});
    cmd(sfe_pkg::OP_WRITE_LATCH_SET);
    latch = 1'b1;
    chk_st();
    d = 8'($urandom);
    d[7:2] = 6'h10;
    sw(d);
    bp = 4'h0;
    latch = 1'b0;
    chk_st();
    cmd(sfe_pkg::OP_STATUS_WRITE_ARM);
    chk_st();
    sw(8'h3C);
    chk_st();
    cmd(sfe_pkg::OP_STATUS_WRITE_ARM);
    sw(8'h0C);
    bp = 4'h3;
    chk_st();
    a = 24'($urandom);
    a[21:16] = 6'h3F;
    er(sfe_pkg::OP_BLOCK32_ERASE, 1'b0, sfe_pkg::ERASE_BLOCK32,
       24'h0);
    er(sfe_pkg::OP_CHIP_ERASE_A, 1'b0, sfe_pkg::ERASE_CHIP, 24'h0);
    a = 24'($urandom);
    a[21:20] = 2'b00;
    cmd(sfe_pkg::OP_WRITE_LATCH_SET);
    latch = 1'b1;
    exp_er.push_back({6'h0, sfe_pkg::ERASE_BLOCK32, a[23:15], 15'h0});
    u_host.frame({sfe_pkg::OP_BLOCK32_ERASE, a}, 32, 0);
    rd({24'h0, sfe_pkg::OP_STATUS_READ}, 8, 8, {24'h0, st(1'b1)});
    cmd(sfe_pkg::OP_WRITE_LATCH_CLEAR);
    rd({24'h0, sfe_pkg::OP_STATUS_READ}, 8, 24,
       {8'h0, st(1'b1), st(1'b1), st(1'b1)});
    wait_idle();
    latch = 1'b0;
    chk_st();
    a = 24'($urandom);
    a[21:20] = 2'b00;
    er(sfe_pkg::OP_BLOCK64_ERASE, 1'b1, sfe_pkg::ERASE_BLOCK64,
       {a[23:16], 16'h0});
    u_host.frame({sfe_pkg::OP_BLOCK64_ERASE, a}, 32, 0);
    check(busy, 1'b0);
    cmd(sfe_pkg::OP_STATUS_WRITE_ARM);
    sw(8'h00);
    bp = 4'h0;
    er(sfe_pkg::OP_CHIP_ERASE_A, 1'b1, sfe_pkg::ERASE_CHIP, 24'h0);
    er(sfe_pkg::OP_CHIP_ERASE_B, 1'b1, sfe_pkg::ERASE_CHIP, 24'h0);
    rd({sfe_pkg::OP_ID_READ_A, 24'h0}, 32, 16,
       {16'h0, sfe_pkg::MAKER_CODE, sfe_pkg::PART_CODE});
    rd({sfe_pkg::OP_ID_READ_B, 24'h1}, 32, 16,
       {16'h0, sfe_pkg::PART_CODE, sfe_pkg::MAKER_CODE});
    rd({24'h0, sfe_pkg::OP_ID_READ_LONG}, 8, 24, {8'h0, sfe_pkg::MAKER_CODE,
       sfe_pkg::MEM_TYPE_CODE, sfe_pkg::CAPACITY_CODE});
    @(posedge clk_in);
    inc_set_in <= 1'b1;
    @(posedge clk_in);
    inc_set_in <= 1'b0;
    inc = 1'b1;
    chk_st();
    cmd(sfe_pkg::OP_WRITE_LATCH_SET);
    cmd(sfe_pkg::OP_WRITE_LATCH_CLEAR);
    inc = 1'b0;
    chk_st();
    u_host.set_wp(1'b0);
    cmd(sfe_pkg::OP_WRITE_LATCH_SET);
    sw(8'h94);
    lock = 1'b1;
    bp = 4'h5;
    chk_st();
    cmd(sfe_pkg::OP_WRITE_LATCH_SET);
    latch = 1'b1;
    sw(8'h00);
    chk_st();
    u_host.set_wp(1'b1);
    sw(8'h00);
    lock = 1'b0;
    bp = 4'h0;
    latch = 1'b0;
    chk_st();
    repeat (4) @(posedge clk_in);
    check(exp_rx.size() + exp_er.size(), 32'h0);
    complete_run();
  end
endmodule : serial_flash_erase_status_id_tb
